// ### logic/shir_pkg.sv
// constants for the interrupt reporting block of the host interface
// assumes a single 200 MHz clock and plain-port register access
//
// How it works
// - active-low request pin while interrupt pending
// - script running: only summary register reachable
// - on-the-fly flag cleared by writing one
// - scsi interrupt sets scsi pending flag
// - dma interrupt sets dma pending flag
// - both pending flags may set together
// - scsi status read returns and clears causes
// - receive fatal: flush dma fifo before interrupt
// - send fatal: fifo may hold bytes, empty clear
// - fifo clear bits: chip test 2, scsi test 1
// - own-id bits 5,6 enable selection, reselection
// - selected bit 5, reselected bit 4
// - selected during select: take alternate address
// - dma fifo empty bit 7 status only
// - pin off at least four clocks, unstack, reassert
package shir_pkg;
  // summary register bit positions
  localparam int SUM_DIP   = 0;
  localparam int SUM_SIP   = 1;
  localparam int SUM_ON_THE_FLY_INTERRUPT  = 2;
  // clear-fifo controls
  localparam int CT3_CLF   = 2;
  localparam int ST3_CSF   = 1;
  // own-id enables
  localparam int OWN_SEL_EN  = 5;
  localparam int OWN_RSEL_EN = 6;
  // scsi status low bit positions
  localparam int SST_SEL   = 5;
  localparam int SST_RSEL  = 4;
  // dma status fifo empty
  localparam int DST_DFE   = 7;
  // pin gap after clearing first level
  localparam int GAP_NS    = 15;
  localparam int CLK_NS    = 5;
  localparam int GAP_CYC   = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] GAP_LAST = 2'(GAP_CYC - 1);
  localparam logic [7:0] ZERO8 = 8'h00;
  typedef enum logic [1:0] {SHIR_IDLE, SHIR_FLUSH, SHIR_POST} shir_fat_t;
endpackage

// ### logic/shir_irq.sv
// interrupt reporting: summary, scsi/dma status, stacking, request pin
// assumes cause pulses and read/write strobes come from the same clock
`timescale 1ns/1ps
module shir_irq (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // cause inputs, one-cycle pulses
  input  wire logic [7:0] scsi_cause_low,
  input  wire logic [7:0] scsi_cause_high,
  input  wire logic [6:0] dma_cause,
  input  wire logic       fly_event,
  input  wire logic       fatal_scsi,
  // enables
  input  wire logic [7:0] scsi_irq_enable_low,
  input  wire logic [7:0] scsi_irq_enable_high,
  input  wire logic [6:0] dma_irq_enable,
  input  wire logic       pin_mask,
  // own id and select state
  input  wire logic [7:0] scsi_own_id_reg,
  input  wire logic       select_active,
  input  wire logic       initiator_role,
  // data path state
  input  wire logic       receiving,
  input  wire logic       dma_fifo_empty,
  input  wire logic       script_running,
  // host register strobes
  input  wire logic       rd_summary,
  input  wire logic       wr_summary,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_scsi_low,
  input  wire logic       rd_scsi_high,
  input  wire logic       rd_dma,
  input  wire logic [7:0] chip_test_three,
  input  wire logic [7:0] scsi_test_three,
  // outputs
  output logic            irq_n,
  output logic [7:0]      interrupt_summary_status,
  output logic [7:0]      scsi_irq_status_low,
  output logic [7:0]      scsi_irq_status_high,
  output logic [7:0]      dma_irq_status,
  output logic            access_refused,
  output logic            flush_req,
  output logic            clear_dma_fifo,
  output logic            clear_scsi_fifo,
  output logic            take_alternate
);
  import shir_pkg::*;

  // first level and stacked status
  logic [7:0] sl_ff;
  logic [7:0] sh_ff;
  logic [7:0] sl_stk_ff;
  logic [7:0] sh_stk_ff;
  logic [6:0] d_ff;
  logic [6:0] d_stk_ff;
  // flags, pin and pulses
  logic       fly_ff;
  logic       sip_ff;
  logic       dip_ff;
  logic       irq_n_ff;
  logic       alt_ff;
  logic [1:0] gap_ff;
  shir_fat_t  fat_ff;
  // read copies
  logic [7:0] rd_sl_ff;
  logic [7:0] rd_sh_ff;
  logic [7:0] rd_d_ff;
  // decode
  logic [7:0] new_sl;
  logic [7:0] new_sh;
  logic [6:0] new_d;
  logic       first_level;
  logic       rd_ok_sl;
  logic       rd_ok_sh;
  logic       rd_ok_d;
  logic       sel_hit;
  logic       rsel_hit;
  logic       scsi_any;
  logic       dma_any;
  logic       first_clear;
  logic       fatal_post;
  logic       gap_idle;

  function automatic logic hits(input logic [7:0] c, input logic [7:0] e);
    hits = |(c & e);
  endfunction

  // reselection only honoured with its enable
  assign sel_hit  = scsi_own_id_reg[OWN_SEL_EN];
  assign rsel_hit = scsi_own_id_reg[OWN_RSEL_EN] && initiator_role;
  always_comb begin
    new_sl = scsi_cause_low;
    new_sl[SST_SEL]  = scsi_cause_low[SST_SEL] && sel_hit;
    new_sl[SST_RSEL] = scsi_cause_low[SST_RSEL] && rsel_hit;
    new_sh = scsi_cause_high;
    new_d  = dma_cause;
  end

  // only summary reachable while script runs
  assign rd_ok_sl = rd_scsi_low && !script_running;
  assign rd_ok_sh = rd_scsi_high && !script_running;
  assign rd_ok_d  = rd_dma && !script_running;
  assign access_refused = script_running && (rd_scsi_low || rd_scsi_high || rd_dma);
  assign first_level = sip_ff || dip_ff;
  assign scsi_any = hits(sl_ff, scsi_irq_enable_low) || hits(sh_ff, scsi_irq_enable_high);
  assign dma_any  = hits({1'b0, d_ff}, {1'b0, dma_irq_enable});
  assign first_clear = (rd_ok_sl || rd_ok_sh || rd_ok_d) && first_level;
  assign gap_idle    = (gap_ff == 2'b00);
  assign fatal_post  = (fat_ff == SHIR_POST);

  // fatal handling: flush on receive before posting
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fat_ff <= SHIR_IDLE;
    end else begin
      case (fat_ff)
        SHIR_IDLE:  if (fatal_scsi) fat_ff <= receiving ? SHIR_FLUSH : SHIR_POST;
        SHIR_FLUSH: if (dma_fifo_empty) fat_ff <= SHIR_POST;
        // held until the post can reach the pending flag
        SHIR_POST:  if (gap_idle && !first_clear) fat_ff <= SHIR_IDLE;
        default:    fat_ff <= SHIR_IDLE;
      endcase
    end
  end
  assign flush_req = (fat_ff == SHIR_FLUSH);

  // first-level and stacked status, new events win over read clears
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sl_ff <= ZERO8;
      sh_ff <= ZERO8;
      d_ff <= ZERO8[6:0];
      sl_stk_ff <= ZERO8;
      sh_stk_ff <= ZERO8;
      d_stk_ff <= ZERO8[6:0];
    end else if (first_level && !first_clear) begin
      sl_stk_ff <= sl_stk_ff | new_sl;
      sh_stk_ff <= sh_stk_ff | new_sh;
      d_stk_ff  <= d_stk_ff | new_d;
    end else if (first_clear) begin
      sl_ff <= (rd_ok_sl ? ZERO8 : sl_ff) | new_sl;
      sh_ff <= (rd_ok_sh ? ZERO8 : sh_ff) | new_sh;
      d_ff  <= (rd_ok_d ? ZERO8[6:0] : d_ff) | new_d;
    end else begin
      sl_ff <= sl_ff | new_sl | sl_stk_ff;
      sh_ff <= sh_ff | new_sh | sh_stk_ff;
      d_ff  <= d_ff | new_d | d_stk_ff;
      sl_stk_ff <= ZERO8;
      sh_stk_ff <= ZERO8;
      d_stk_ff <= ZERO8[6:0];
    end
  end

  // pending flags; both may set together
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sip_ff <= 1'b0;
      dip_ff <= 1'b0;
    end else if (first_clear) begin
      sip_ff <= 1'b0;
      dip_ff <= 1'b0;
    end else if (gap_idle) begin
      // a posted fatal condition counts as scsi type
      sip_ff <= sip_ff || scsi_any || fatal_post;
      dip_ff <= dip_ff || dma_any;
    end
  end

  // on-the-fly flag: set wins over write-one clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fly_ff <= 1'b0;
    end else if (fly_event) begin
      fly_ff <= 1'b1;
    end else if (wr_summary && wr_data[SUM_ON_THE_FLY_INTERRUPT]) begin
      fly_ff <= 1'b0;
    end
  end

  // pin gap counter after first level cleared
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gap_ff <= 2'b00;
    end else if (first_clear) begin
      gap_ff <= GAP_LAST + 2'b01;
    end else if (!gap_idle) begin
      gap_ff <= gap_ff - 2'b01;
    end
  end

  // request pin
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_n_ff <= 1'b1;
    end else begin
      irq_n_ff <= !((sip_ff || dip_ff || fly_ff) && !pin_mask
                    && gap_idle && !first_clear);
    end
  end
  assign irq_n = irq_n_ff;

  // alternate branch when (re)selected during select
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alt_ff <= 1'b0;
    end else begin
      alt_ff <= select_active && (new_sl[SST_SEL] || new_sl[SST_RSEL]);
    end
  end
  assign take_alternate = alt_ff;

  // read data registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_sl_ff <= ZERO8;
      rd_sh_ff <= ZERO8;
      rd_d_ff <= ZERO8;
    end else begin
      rd_sl_ff <= sl_ff;
      rd_sh_ff <= sh_ff;
      rd_d_ff  <= {dma_fifo_empty, d_ff};
    end
  end
  assign scsi_irq_status_low  = rd_sl_ff;
  assign scsi_irq_status_high = rd_sh_ff;
  assign dma_irq_status       = rd_d_ff;
  assign interrupt_summary_status = {5'h00, fly_ff, sip_ff, dip_ff};
  assign clear_dma_fifo  = chip_test_three[CT3_CLF];
  assign clear_scsi_fifo = scsi_test_three[ST3_CSF];

  // checks
  pin_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    first_clear |=> irq_n [*3]) else $error("pin not off three clocks");
  pin_on_a: assert property (@(posedge ref_clk) disable iff (rst)
    (sip_ff && !pin_mask && gap_ff == 2'b00 && !first_clear) |=> !irq_n)
    else $error("pin not asserted");
  fly_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    fly_event |=> fly_ff) else $error("fly flag lost");
  fly_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    (fly_ff && !(wr_summary && wr_data[SUM_ON_THE_FLY_INTERRUPT])) |=> fly_ff)
    else $error("fly flag cleared without write");
  refuse_a: assert property (@(posedge ref_clk) disable iff (rst)
    (script_running && rd_scsi_low && sip_ff) |=> sip_ff)
    else $error("read taken while running");
  dfe_a: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> dma_irq_status[DST_DFE] == $past(dma_fifo_empty))
    else $error("fifo empty bit wrong");
  flush_a: assert property (@(posedge ref_clk) disable iff (rst)
    (fat_ff == SHIR_IDLE && fatal_scsi && receiving) |=> flush_req)
    else $error("no flush on receive fatal");
  both_a: assert property (@(posedge ref_clk) disable iff (rst)
    (scsi_any && dma_any && gap_ff == 2'b00 && !first_clear) |=> sip_ff && dip_ff)
    else $error("pending flags not both set");
  rsel_a: assert property (@(posedge ref_clk) disable iff (rst)
    !scsi_own_id_reg[OWN_RSEL_EN] |-> !new_sl[SST_RSEL])
    else $error("reselect honoured without enable");
  sip_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    (scsi_any && gap_idle && !first_clear) |=> sip_ff)
    else $error("scsi pending not set");
  dip_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    (dma_any && gap_idle && !first_clear) |=> dip_ff)
    else $error("dma pending not set");
  read_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    first_clear |=> !sip_ff && !dip_ff)
    else $error("read did not clear pending");
  fatal_post_a: assert property (@(posedge ref_clk) disable iff (rst)
    (fatal_post && gap_idle && !first_clear) |=> sip_ff)
    else $error("fatal not posted");
  alt_branch_a: assert property (@(posedge ref_clk) disable iff (rst)
    (select_active && new_sl[SST_SEL]) |=> take_alternate)
    else $error("alternate branch missed");
  refused_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    (script_running && rd_scsi_high) |-> access_refused)
    else $error("refused read not flagged");
  stack_c: cover property (@(posedge ref_clk) disable iff (rst) first_clear ##4 !irq_n);
  fly_c: cover property (@(posedge ref_clk) disable iff (rst) fly_ff ##1 !fly_ff);
  alt_c: cover property (@(posedge ref_clk) disable iff (rst) take_alternate);
  both_c: cover property (@(posedge ref_clk) disable iff (rst) sip_ff && dip_ff);
  flush_c: cover property (@(posedge ref_clk) disable iff (rst) flush_req ##1 !flush_req);
endmodule // shir_irq

// ### dv/shir_host_model.sv
// host model: answers the request pin by reading and clearing status
// assumes strobes are sampled by the design at ref_clk rising edges
`timescale 1ns/1ps
module shir_host_model (
  // clock and control
  input  wire logic       ref_clk,
  input  wire logic       en,
  // from the design
  input  wire logic       irq_n,
  input  wire logic [7:0] summary,
  input  wire logic [7:0] dma_st,
  // host strobes
  output logic            rd_summary,
  output logic            wr_summary,
  output logic [7:0]      wr_data,
  output logic            rd_scsi_low,
  output logic            rd_scsi_high,
  output logic            rd_dma,
  output logic [7:0]      chip_test_three,
  output logic [7:0]      scsi_test_three
);
  import shir_pkg::*;
  logic [7:0] s;
  initial {rd_summary, wr_summary, wr_data, rd_scsi_low, rd_scsi_high, rd_dma} = '0;
  initial {chip_test_three, scsi_test_three} = '0;
  always begin
    @(posedge ref_clk);
    if (en && irq_n === 1'b0) begin
      rd_summary <= 1'b1;
      @(posedge ref_clk);
      s = summary;
      rd_summary <= 1'b0;
      if (s[SUM_ON_THE_FLY_INTERRUPT]) begin
        wr_summary <= 1'b1;
        wr_data <= 8'h01 << SUM_ON_THE_FLY_INTERRUPT;
        @(posedge ref_clk);
        wr_summary <= 1'b0;
        wr_data <= ~wr_data;
      end
      if (s[SUM_SIP] || s[SUM_DIP]) begin
        rd_scsi_low <= s[SUM_SIP];
        rd_scsi_high <= s[SUM_SIP];
        rd_dma <= s[SUM_DIP];
        @(posedge ref_clk);
        {rd_scsi_low, rd_scsi_high, rd_dma} <= 3'h0;
        if (dma_st[DST_DFE] !== 1'b1) begin
          chip_test_three[CT3_CLF] <= 1'b1;
          scsi_test_three[ST3_CSF] <= 1'b1;
          @(posedge ref_clk);
          chip_test_three <= 8'h00;
          scsi_test_three <= 8'h00;
        end
      end
      repeat (6) @(posedge ref_clk);
    end
  end
endmodule // shir_host_model

// ### dv/shir_irq_bench.sv
// bench for the interrupt reporting block
// assumes shir_host_model services the pin; ref_clk at 200 MHz
`timescale 1ns/1ps
module scsi_host_interrupt_reporting_bench;
  import shir_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, host_en = 1'b0, fly = 1'b0, fatal = 1'b0;
  logic sel_act = 1'b0, init_role = 1'b0, recv = 1'b0, dfe = 1'b0, run = 1'b0;
  logic [7:0] cause_lo = '0, cause_hi = '0, own = '0, en8 = '1;
  logic [6:0] dma_c = '0, en7 = '1;
  logic rd_sum, wr_sum, rd_lo, rd_hi, rd_dm, irq_n, refused, flush, clr_d, clr_s, alt;
  logic [7:0] wr_d, ct3, st3, summ, st_lo, st_hi, st_dma, v;
  logic seen_low = 1'b0, short_gap = 1'b0, alt_seen = 1'b0;
  int seed = 45, hi_run = 0, falls = 0, f0, miscompares = 0, n_compared = 0;
  shir_irq shir_irq_inst (.ref_clk(ref_clk), .rst(rst), .scsi_cause_low(cause_lo),
    .scsi_cause_high(cause_hi), .dma_cause(dma_c), .fly_event(fly), .fatal_scsi(fatal),
    .scsi_irq_enable_low(en8), .scsi_irq_enable_high(en8), .dma_irq_enable(en7),
    .pin_mask(1'b0), .scsi_own_id_reg(own), .select_active(sel_act),
    .initiator_role(init_role), .receiving(recv), .dma_fifo_empty(dfe), .script_running(run),
    .rd_summary(rd_sum), .wr_summary(wr_sum), .wr_data(wr_d), .rd_scsi_low(rd_lo),
    .rd_scsi_high(rd_hi), .rd_dma(rd_dm), .chip_test_three(ct3), .scsi_test_three(st3),
    .irq_n(irq_n), .interrupt_summary_status(summ), .scsi_irq_status_low(st_lo),
    .scsi_irq_status_high(st_hi), .dma_irq_status(st_dma), .access_refused(refused),
    .flush_req(flush), .clear_dma_fifo(clr_d), .clear_scsi_fifo(clr_s), .take_alternate(alt));
  shir_host_model shir_host_model_inst (.ref_clk(ref_clk), .en(host_en), .irq_n(irq_n),
    .summary(summ), .dma_st(st_dma), .rd_summary(rd_sum), .wr_summary(wr_sum),
    .wr_data(wr_d), .rd_scsi_low(rd_lo), .rd_scsi_high(rd_hi), .rd_dma(rd_dm),
    .chip_test_three(ct3), .scsi_test_three(st3));
  always #2.5 ref_clk = ~ref_clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] sum_of(input logic i, input logic s, input logic d);
    sum_of = 8'h00;
    sum_of[SUM_ON_THE_FLY_INTERRUPT] = i;
    sum_of[SUM_SIP] = s;
    sum_of[SUM_DIP] = d;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic pulse(input logic [7:0] lo, hi, input logic [6:0] dm, input logic fl, ft);
    @(posedge ref_clk);
    {cause_lo, cause_hi, dma_c, fly, fatal} <= {lo, hi, dm, fl, ft};
    @(posedge ref_clk);
    {cause_lo, cause_hi, dma_c, fly, fatal} <= '0;
    tick(4);
  endtask
  // host pass while the script runs: detailed reads refused
  task automatic busy_pass;
    run <= 1'b1;
    host_en <= 1'b1;
    tick(8);
    host_en <= 1'b0;
    tick(4);
    run <= 1'b0;
  endtask
  task automatic serve;
    host_en <= 1'b1;
    tick(40);
    host_en <= 1'b0;
    check(summ, 8'h00);
  endtask
  // pin gap and alternate-branch monitors
  always @(posedge ref_clk) begin
    alt_seen <= alt_seen | (alt === 1'b1);
    if (irq_n === 1'b0) begin
      if (seen_low && hi_run > 0 && hi_run < 3) short_gap <= 1'b1;
      if (hi_run > 0) falls <= falls + 1;
      seen_low <= 1'b1;
      hi_run <= 0;
    end else hi_run <= hi_run + 1;
  end
  always @(negedge ref_clk) begin
    if (!rst) check({6'h0, clr_d, clr_s}, {6'h0, ct3[CT3_CLF], st3[ST3_CSF]});
    if (run && (rd_lo || rd_hi || rd_dm)) check({7'h0, refused}, 8'h01);
  end
  initial begin
    #20000;
    miscompares++;
    end_of_test;
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    tick(1);
    check({7'h0, irq_n}, 8'h01);
    check(summ, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed)) | 8'h01;
      pulse(8'h00, v, 7'h00, 1'b0, 1'b0);
      check(st_hi, v);
      check(summ, sum_of(1'b0, 1'b1, 1'b0));
      check({7'h0, irq_n}, 8'h00);
      busy_pass;
      check(summ, sum_of(1'b0, 1'b1, 1'b0));
      serve;
      check(st_hi, 8'h00);
      check({7'h0, irq_n}, 8'h01);
    end
    f0 = falls;
    pulse(8'h01, 8'h00, 7'h00, 1'b0, 1'b0);
    pulse(8'h02, 8'h00, 7'h00, 1'b0, 1'b0);
    check(st_lo, 8'h01);
    serve;
    check(8'(falls - f0), 8'h02);
    check({7'h0, short_gap}, 8'h00);
    pulse(8'h01, 8'h00, 7'h01, 1'b0, 1'b0);
    check(summ, sum_of(1'b0, 1'b1, 1'b1));
    check(st_dma, 8'h01);
    serve;
    pulse(8'h01, 8'h00, 7'h00, 1'b1, 1'b0);
    tick(20);
    check(summ, sum_of(1'b1, 1'b1, 1'b0));
    busy_pass;
    check(summ, sum_of(1'b0, 1'b1, 1'b0));
    serve;
    dfe <= 1'b1;
    tick(3);
    check({st_dma[DST_DFE], 6'h0, irq_n}, 8'h81);
    dfe <= 1'b0;
    pulse(8'h00, 8'h00, 7'h00, 1'b0, 1'b1);
    check({st_dma[DST_DFE], 6'h0, irq_n}, 8'h00);
    serve;
    recv <= 1'b1;
    pulse(8'h00, 8'h00, 7'h00, 1'b0, 1'b1);
    check({6'h0, flush, irq_n}, 8'h03);
    dfe <= 1'b1;
    tick(4);
    check({6'h0, flush, irq_n}, 8'h00);
    serve;
    own <= 8'h01 << OWN_SEL_EN;
    init_role <= 1'b1;
    sel_act <= 1'b1;
    pulse(8'h01 << SST_RSEL, 8'h00, 7'h00, 1'b0, 1'b0);
    check(st_lo, 8'h00);
    pulse(8'h01 << SST_SEL, 8'h00, 7'h00, 1'b0, 1'b0);
    check(st_lo, 8'h01 << SST_SEL);
    check({7'h0, alt_seen}, 8'h01);
    serve;
    own <= 8'h01 << OWN_SEL_EN | 8'h01 << OWN_RSEL_EN;
    pulse(8'h01 << SST_RSEL, 8'h00, 7'h00, 1'b0, 1'b0);
    check(st_lo, 8'h01 << SST_RSEL);
    serve;
    end_of_test;
  end
endmodule // scsi_host_interrupt_reporting_bench
